// File: rtl/srcp_pkg.sv
// constants and types for the serial remote command parser.
// assumes a byte-wide receiver and transmitter on the same clock.
package srcp_pkg;
  // ==========================================================
  // character codes
  localparam logic [7:0] CH_ESC   = 8'h1B;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_LBR   = 8'h5B;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_M     = 8'h4D;
  localparam logic [7:0] CH_U     = 8'h55;
  localparam logic [7:0] CH_N     = 8'h4E;
  localparam logic [7:0] CH_UA    = 8'h41;
  localparam logic [7:0] CH_UZ    = 8'h5A;
  localparam logic [7:0] CH_LA    = 8'h61;
  localparam logic [7:0] CH_LZ    = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // ==========================================================
  // names, limits, exponents
  localparam logic [63:0] LONG_NAME  = 64'h5449_4D45_2F44_4956;
  localparam logic [15:0] SHORT_NAME = 16'h5444;
  localparam logic [3:0]  SHORT_LEN  = 4'h2;
  localparam logic [3:0]  LONG_LEN   = 4'h8;
  localparam logic [7:0]  PORT_ADDR_MIN = 8'h1F;
  localparam int          LINE_DEPTH = 32;
  localparam int          LINE_AW    = 5;
  localparam logic [4:0]  REPLY_LAST = 5'h13;
  localparam logic [1:0]  SW_SETTLE  = 2'h2;
  localparam logic [1:0]  MAX_DIGITS = 2'h3;
  localparam logic signed [7:0] EXP_ONE   = 8'sh01;
  localparam logic signed [7:0] EXP_MILLI = -8'sh03;
  localparam logic signed [7:0] EXP_MICRO = -8'sh06;
  localparam logic signed [7:0] EXP_NANO  = -8'sh09;
  localparam logic [7:0]  TEN = 8'h0A;
  // ==========================================================
  // types
  typedef struct packed {
    logic [11:0]       digits;
    logic signed [7:0] exponent;
  } srcp_tb_t;
  localparam srcp_tb_t TB_RESET = {12'h100, 8'h00};
  typedef enum logic [2:0] {
    ST_COLLECT = 3'b000,
    ST_NAME    = 3'b001,
    ST_ARG     = 3'b010,
    ST_EXPO    = 3'b011,
    ST_UNIT    = 3'b100,
    ST_REPLY   = 3'b101
  } srcp_state_t;
endpackage

// File: rtl/srcp_parser.sv
// serial remote command parser: echo, local/remote, timebase query/set.
// assumes rx/tx byte handshakes on ref_clk; addr_switch is a pin.
`timescale 1ns/1ps
module srcp_parser
  import srcp_pkg::*;
(
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     reset_n,
  // rear address switch pin
  input  wire logic [7:0] addr_switch,
  // received characters
  input  wire logic     rx_valid,
  input  wire logic [7:0] rx_data,
  output logic          rx_ready,
  // transmitted characters
  output logic          tx_valid,
  output logic [7:0]    tx_data,
  input  wire logic     tx_ready,
  // status and settings
  output logic          port_enable,
  output logic          remote_mode,
  output logic          echo_on,
  output logic          menu_restore,
  output logic          cmd_error,
  output logic          timebase_update,
  output srcp_tb_t      timebase
);
  // ==========================================================
  // storage
  srcp_state_t state_reg;
  logic [7:0]  line_mem [LINE_DEPTH];
  logic [LINE_AW:0] lcount_reg, pidx_reg;
  logic [7:0]  sw_meta_reg, sw_sync_reg;
  logic [1:0]  settle_reg;
  logic        captured_reg, port_en_reg, esc_reg, echo_reg, remote_reg, overflow_reg;
  logic        txv_reg, menu_reg, err_reg, upd_reg;
  logic [7:0]  txd_reg;
  logic [3:0]  nidx_reg;
  logic        short_ok_reg, long_ok_reg, point_reg, got_reg, query_reg, eneg_reg, unit_reg;
  logic [1:0]  ndig_reg;
  logic [11:0] dig_reg;
  logic signed [7:0] adj_reg, unit_exp_reg;
  logic [7:0]  eacc_reg;
  logic [4:0]  ridx_reg;
  srcp_tb_t    tb_reg;
  // ==========================================================
  // decode
  wire        tx_free  = ~txv_reg | tx_ready;
  wire        rx_take  = rx_valid & rx_ready;
  wire [7:0]  raw_ch   = line_mem[pidx_reg[LINE_AW-1:0]];
  wire        is_lower = (raw_ch >= CH_LA) && (raw_ch <= CH_LZ);
  wire [7:0]  ch       = is_lower ? (raw_ch & ~CASE_BIT) : raw_ch;
  wire        at_end   = (pidx_reg == lcount_reg);
  wire        is_digit = (ch >= CH_ZERO) && (ch <= CH_NINE);
  wire [3:0]  dval     = ch[3:0];
  wire        is_alpha = (ch >= CH_UA) && (ch <= CH_UZ);
  wire        is_sep   = (ch == CH_SP) || (ch == CH_COMMA) || (ch == CH_EQ);
  wire [7:0]  short_ch = nidx_reg[0] ? SHORT_NAME[7:0] : SHORT_NAME[15:8];
  wire [7:0]  long_ch  = LONG_NAME[{~nidx_reg[2:0], 3'b000} +: 8];
  wire        name_ok  = ((nidx_reg == SHORT_LEN) && short_ok_reg)
                       || ((nidx_reg == LONG_LEN) && long_ok_reg);
  wire signed [7:0] eterm = eneg_reg ? -$signed(eacc_reg) : $signed(eacc_reg);
  wire signed [7:0] exp_final = adj_reg + eterm + unit_exp_reg;
  wire        in_parse = (state_reg != ST_COLLECT) && (state_reg != ST_REPLY);
  wire        bad_name = (state_reg == ST_NAME) && is_sep && !name_ok;
  wire [7:0]  e_abs    = tb_reg.exponent[7] ? 8'(-tb_reg.exponent) : 8'(tb_reg.exponent);
  wire [7:0]  e_tens   = 8'(e_abs / TEN);
  wire [7:0]  e_ones   = 8'(e_abs % TEN);
  logic [7:0] reply_ch;
  always_comb
  begin
    reply_ch = CH_LF;
    case (ridx_reg)
      5'h08: reply_ch = CH_SP;
      5'h09: reply_ch = {4'h3, tb_reg.digits[11:8]};
      5'h0A: reply_ch = {4'h3, tb_reg.digits[7:4]};
      5'h0B: reply_ch = {4'h3, tb_reg.digits[3:0]};
      5'h0C: reply_ch = CH_E;
      5'h0D: reply_ch = tb_reg.exponent[7] ? CH_MINUS : CH_PLUS;
      5'h0E: reply_ch = CH_ZERO + e_tens;
      5'h0F: reply_ch = CH_ZERO + e_ones;
      5'h10: reply_ch = CH_SP;
      5'h11: reply_ch = CH_S;
      5'h12: reply_ch = CH_CR;
      default:
        if (ridx_reg < 5'h08)
          reply_ch = LONG_NAME[{~ridx_reg[2:0], 3'b000} +: 8];
    endcase
  end
  // echo skips the byte that turns echo off
  wire echo_now = rx_take && echo_reg && !(esc_reg && rx_data == CH_LBR);
  assign rx_ready = port_en_reg && (state_reg == ST_COLLECT) && tx_free;
  // ==========================================================
  // switch capture: sampled once, after the synchroniser settles
  always_ff @(posedge ref_clk)
  begin
    sw_meta_reg <= addr_switch;
    sw_sync_reg <= sw_meta_reg;
    if (!reset_n)
    begin
      settle_reg   <= 2'h0;
      captured_reg <= 1'b0;
      port_en_reg  <= 1'b0;
    end
    else if (!captured_reg)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == SW_SETTLE)
      begin
        captured_reg <= 1'b1;
        port_en_reg  <= (sw_sync_reg > PORT_ADDR_MIN);
      end
    end
  end
  // ==========================================================
  // line buffer writes
  always_ff @(posedge ref_clk)
    if (rx_take && !esc_reg && rx_data != CH_ESC && rx_data != CH_CR
        && lcount_reg < LINE_DEPTH[LINE_AW:0])
      line_mem[lcount_reg[LINE_AW-1:0]] <= rx_data;
  // ==========================================================
  // transmit register: echo in collect, reply afterwards
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      txv_reg <= 1'b0;
      txd_reg <= 8'h00;
    end
    else if (echo_now)
    begin
      txv_reg <= 1'b1;
      txd_reg <= rx_data;
    end
    else if (state_reg == ST_REPLY && tx_free)
    begin
      txv_reg <= 1'b1;
      txd_reg <= reply_ch;
    end
    else if (tx_ready)
      txv_reg <= 1'b0;
  end
  // ==========================================================
  // escape sequences and mode flags
  always_ff @(posedge ref_clk)
  begin
    menu_reg <= 1'b0;
    if (!reset_n)
    begin
      esc_reg    <= 1'b0;
      echo_reg   <= 1'b1;
      remote_reg <= 1'b0;
    end
    else if (rx_take)
    begin
      esc_reg <= (rx_data == CH_ESC) && !esc_reg;
      if (esc_reg && rx_data == CH_LBR)
        echo_reg <= 1'b0;
      if (esc_reg && rx_data == CH_R)
        remote_reg <= 1'b1;
      if (esc_reg && rx_data == CH_L)
      begin
        remote_reg <= 1'b0;
        menu_reg   <= 1'b1;
      end
    end
  end
  // ==========================================================
  // line collection, parse walk and reply sequencing
  always_ff @(posedge ref_clk)
  begin
    upd_reg <= 1'b0;
    err_reg <= 1'b0;
    if (!reset_n)
    begin
      state_reg <= ST_COLLECT;
      lcount_reg <= '0;
      pidx_reg <= '0;
      overflow_reg <= 1'b0;
      ridx_reg <= 5'h00;
      tb_reg <= TB_RESET;
      {nidx_reg, short_ok_reg, long_ok_reg, point_reg, got_reg} <= '0;
      {query_reg, eneg_reg, unit_reg, ndig_reg, dig_reg} <= '0;
      {adj_reg, unit_exp_reg, eacc_reg} <= '0;
    end
    else
    begin
      case (state_reg)
        ST_COLLECT:
          if (rx_take && !esc_reg && rx_data != CH_ESC)
          begin
            if (rx_data == CH_CR)
            begin
              state_reg <= overflow_reg ? ST_COLLECT : ST_NAME;
              err_reg <= overflow_reg;
              lcount_reg <= overflow_reg ? '0 : lcount_reg;
              overflow_reg <= 1'b0;
              pidx_reg <= '0;
              {nidx_reg, point_reg, got_reg, query_reg, eneg_reg, unit_reg} <= '0;
              {short_ok_reg, long_ok_reg} <= 2'b11;
              {ndig_reg, dig_reg, adj_reg, unit_exp_reg, eacc_reg} <= '0;
            end
            else if (rx_data != CH_LF)
            begin
              if (lcount_reg < LINE_DEPTH[LINE_AW:0])
                lcount_reg <= lcount_reg + 1'b1;
              else
                overflow_reg <= 1'b1;
            end
          end
        ST_REPLY:
          if (tx_free)
          begin
            ridx_reg <= ridx_reg + 5'h01;
            if (ridx_reg == REPLY_LAST)
              state_reg <= ST_COLLECT;
          end
        default:
          if (at_end)
          begin
            lcount_reg <= '0;
            ridx_reg <= 5'h00;
            if (state_reg == ST_NAME || (!query_reg && !got_reg))
            begin
              state_reg <= ST_COLLECT;
              err_reg <= 1'b1;
            end
            else if (query_reg)
              state_reg <= ST_REPLY;
            else
            begin
              state_reg <= ST_COLLECT;
              err_reg <= !remote_reg;
              if (remote_reg)
              begin
                upd_reg <= 1'b1;
                tb_reg <= {dig_reg, exp_final};
              end
            end
          end
          else if (bad_name)
          begin
            state_reg <= ST_COLLECT;
            lcount_reg <= '0;
            err_reg <= 1'b1;
          end
          else
          begin
            pidx_reg <= pidx_reg + 1'b1;
            case (state_reg)
              ST_NAME:
                if (is_sep)
                  state_reg <= ST_ARG;
                else
                begin
                  short_ok_reg <= short_ok_reg && (nidx_reg < SHORT_LEN) && (ch == short_ch);
                  long_ok_reg <= long_ok_reg && (nidx_reg < LONG_LEN) && (ch == long_ch);
                  if (nidx_reg <= LONG_LEN)
                    nidx_reg <= nidx_reg + 4'h1;
                end
              ST_ARG:
                if (is_digit && !query_reg)
                begin
                  got_reg <= 1'b1;
                  if (dig_reg == 12'h000 && dval == 4'h0)
                    adj_reg <= point_reg ? adj_reg - EXP_ONE : adj_reg;
                  else if (ndig_reg < MAX_DIGITS)
                  begin
                    dig_reg <= {dig_reg[7:0], dval};
                    ndig_reg <= ndig_reg + 2'h1;
                    adj_reg <= point_reg ? adj_reg - EXP_ONE : adj_reg;
                  end
                  else if (!point_reg)
                    adj_reg <= adj_reg + EXP_ONE;
                end
                else if (ch == CH_DOT && !point_reg && !query_reg)
                  point_reg <= 1'b1;
                else if (ch == CH_QM && !got_reg && !point_reg)
                  query_reg <= 1'b1;
                else if (ch == CH_E && got_reg)
                  state_reg <= ST_EXPO;
                else if ((is_alpha || ch == CH_SP) && got_reg)
                begin
                  state_reg <= ST_UNIT;
                  pidx_reg <= pidx_reg;
                end
                else if (ch != CH_SP || query_reg)
                  state_reg <= ST_NAME;
              ST_EXPO:
                if (ch == CH_MINUS)
                  eneg_reg <= 1'b1;
                else if (is_digit)
                  eacc_reg <= 8'(eacc_reg * TEN + {4'h0, dval});
                else if (is_alpha || ch == CH_SP)
                begin
                  state_reg <= ST_UNIT;
                  pidx_reg <= pidx_reg;
                end
                else if (ch != CH_PLUS)
                  state_reg <= ST_NAME;
              default:
                if (is_alpha && !unit_reg)
                begin
                  unit_reg <= 1'b1;
                  case (ch)
                    CH_M:    unit_exp_reg <= EXP_MILLI;
                    CH_U:    unit_exp_reg <= EXP_MICRO;
                    CH_N:    unit_exp_reg <= EXP_NANO;
                    CH_S:    unit_exp_reg <= '0;
                    default: state_reg <= ST_NAME;
                  endcase
                end
            endcase
          end
      endcase
    end
  end
  // a malformed argument parks in ST_NAME, which at end of line is an error
  // ==========================================================
  // outputs
  assign tx_valid = txv_reg;
  assign tx_data = txd_reg;
  assign port_enable = port_en_reg;
  assign remote_mode = remote_reg;
  assign echo_on = echo_reg;
  assign menu_restore = menu_reg;
  assign cmd_error = err_reg;
  assign timebase_update = upd_reg;
  assign timebase = tb_reg;
  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_echo_char: assert property (rx_take && echo_reg && !esc_reg |=>
    tx_valid && tx_data == $past(rx_data)) else $error("echo missing");
  a_echo_stop: assert property (rx_take && esc_reg && rx_data == CH_LBR |=>
    !echo_on [*3]) else $error("echo not stopped");
  a_port_gate: assert property (!port_enable |-> !rx_ready ##1 !tx_valid)
    else $error("disabled port accepted data");
  a_reply_start: assert property (state_reg == ST_REPLY && ridx_reg == 5'h00 && tx_free
    |=> tx_valid && tx_data == LONG_NAME[63:56]) else $error("reply start wrong");
  a_reply_bound: assert property ($rose(state_reg == ST_REPLY) |->
    ##[20:600] state_reg == ST_COLLECT) else $error("reply too long");
  a_remote_enter: assert property (rx_take && esc_reg && rx_data == CH_R
    |=> remote_mode) else $error("remote not entered");
  a_local_exit: assert property (rx_take && esc_reg && rx_data == CH_L
    |=> !remote_mode && menu_restore) else $error("local not restored");
  a_set_gated: assert property (timebase_update |-> remote_mode)
    else $error("set outside remote");
  a_set_at_end: assert property (timebase != $past(timebase) |-> timebase_update
    && $past(at_end) && $past(in_parse)) else $error("setting changed early");
  a_cr_parse: assert property (rx_take && !esc_reg && rx_data == CH_CR && !overflow_reg
    |=> state_reg == ST_NAME && pidx_reg == '0) else $error("line not parsed");
  c_query: cover property (state_reg == ST_REPLY && ridx_reg == REPLY_LAST && tx_free);
  c_set: cover property (timebase_update);
  c_echo_off: cover property (rx_take && esc_reg && rx_data == CH_LBR);
  c_menu: cover property (menu_restore);
endmodule // srcp_parser

// File: verification/srcp_host.sv
// host terminal model: sends queued characters to the parser and collects its output.
// assumes the parser samples on the rising edge of ref_clk; the bench fills send_q.
`timescale 1ns/1ps
module srcp_host
  import srcp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // pacing of the receiving side
  input  wire logic       slow,
  // characters toward the parser
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  // characters from the parser
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // ==========================================================
  // one step per clock: take the outcome of the edge, then drive
  always @(posedge ref_clk)
  begin
    if (rx_valid && rx_ready === 1'b1 && reset_n) void'(send_q.pop_front());
    if (tx_valid === 1'b1 && tx_ready) got_q.push_back(tx_data);
    #1;
    // a character is held until taken; idle data toggles so a stale byte never reads as valid
    rx_valid = (send_q.size() != 0);
    rx_data  = rx_valid ? send_q[0] : ~rx_data;
    // slow pacing stalls the parser's output on about one cycle in three
    tx_ready = !slow || ($urandom_range(2) != 0);
  end
endmodule // srcp_host

// File: verification/test_srcp_parser.sv
// self-checking bench for the serial remote command parser with a host model.
// assumes one 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
module test_srcp_parser
  import srcp_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       reset_n;
  logic [7:0] addr_switch;
  logic       slow;
  logic       rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic       port_enable, remote_mode, echo_on, menu_restore, cmd_error, timebase_update;
  srcp_tb_t   timebase;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  int         n_err = 0;
  int         n_upd = 0;
  int         n_menu = 0;
  // behavioural model of the parser
  logic [7:0] exp_q[$];
  bit         echo_m, remote_m, esc_m;
  longint     cur_ps;
  // the short command name is spelled as octal escapes
  string      set_cmd[6] = '{"\124\104 2MS", "TIME/DIV 2 MS", "\164\144 2e-3",
                             "\124\144 .002", "tIMe/dIv 5ns", "\124\104 1"};
  longint     set_ps[6]  = '{64'h7735_9400, 64'h7735_9400, 64'h7735_9400, 64'h7735_9400,
                             64'h1388, 64'hE8_D4A5_1000};

  always #25 ref_clk = ~ref_clk;

  srcp_parser u_srcp_parser (.ref_clk(ref_clk), .reset_n(reset_n), .addr_switch(addr_switch),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .port_enable(port_enable),
    .remote_mode(remote_mode), .echo_on(echo_on), .menu_restore(menu_restore),
    .cmd_error(cmd_error), .timebase_update(timebase_update), .timebase(timebase));

  srcp_host u_srcp_host (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // ==========================================================
  // pulse counters and run limit
  always @(posedge ref_clk)
  begin
    if (cmd_error === 1'b1) n_err++;
    if (timebase_update === 1'b1) n_upd++;
    if (menu_restore === 1'b1) n_menu++;
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // timebase in picoseconds; unknown digits stay unknown
  function automatic logic signed [63:0] to_ps(input srcp_tb_t t);
    logic signed [63:0] v;
    v = t.digits[11:8] * 100 + t.digits[7:4] * 10 + t.digits[3:0];
    for (int e = 0; e < int'(t.exponent) + 12; e++) v = v * 10;
    for (int e = 0; e > int'(t.exponent) + 12; e--) v = v / 10;
    return v;
  endfunction

  task automatic do_reset(input int n);
    @(posedge ref_clk);
    #1 reset_n = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    {echo_m, remote_m, esc_m} = 3'b100;
    cur_ps = 64'h5AF3_107A_4000;
    exp_q.delete();
  endtask

  task automatic send(input string s);
    logic [7:0] c;
    for (int i = 0; i < s.len(); i++)
    begin
      c = s[i];
      if (echo_m && !(esc_m && c == CH_LBR)) exp_q.push_back(c);
      if (esc_m && c == CH_R) remote_m = 1'b1;
      if (esc_m && c == CH_L) remote_m = 1'b0;
      if (esc_m && c == CH_LBR) echo_m = 1'b0;
      esc_m = (c == CH_ESC) && !esc_m;
      u_srcp_host.send_q.push_back(c);
    end
  endtask

  // waits for the host queue to drain and the parser to sit idle
  task automatic settle();
    int quiet;
    quiet = 0;
    for (int n = 0; n < 3000 && quiet < 4; n++)
    begin
      @(posedge ref_clk);
      #2;
      if (u_srcp_host.send_q.size() == 0 && rx_ready === 1'b1 && tx_valid === 1'b0)
        quiet++;
      else
        quiet = 0;
    end
    chk(quiet, 4);
  endtask

  task automatic cmp_out();
    chk(u_srcp_host.got_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < u_srcp_host.got_q.size(); i++)
      chk(u_srcp_host.got_q[i], exp_q[i]);
    chk(echo_on, echo_m);
    chk(remote_mode, remote_m);
    u_srcp_host.got_q.delete();
    exp_q.delete();
  endtask

  // one command line: no timebase update may happen before the carriage return
  task automatic run(input string body, input int upd, input int err, input longint ps,
                     input string reply);
    int u0;
    int e0;
    u0 = n_upd;
    e0 = n_err;
    slow = 1'($urandom_range(1));
    send(body);
    settle();
    chk(n_upd - u0, 0);
    chk(to_ps(timebase), cur_ps);
    send("\015");
    settle();
    for (int i = 0; i < reply.len(); i++) exp_q.push_back(reply[i]);
    if (upd != 0) cur_ps = ps;
    chk(n_upd - u0, upd);
    chk(n_err - e0, err);
    chk(to_ps(timebase), cur_ps);
    cmp_out();
  endtask

  task automatic esc(input string s);
    int m0;
    m0 = n_menu;
    send(s);
    settle();
    chk(n_menu - m0, s == "\033L");
    cmp_out();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int n;
    void'($urandom(47981));
    reset_n = 1'b0;
    addr_switch = PORT_ADDR_MIN;
    slow = 1'b0;
    do_reset(16);
    chk(port_enable, 1'b0);
    u_srcp_host.send_q.push_back(CH_UA);
    repeat (20) @(posedge ref_clk);
    #1;
    chk(u_srcp_host.send_q.size(), 1);
    u_srcp_host.send_q.delete();
    addr_switch = 8'(PORT_ADDR_MIN + 8'h01 + 8'($urandom_range(223)));
    do_reset(2);
    chk(port_enable, 1'b1);
    chk(to_ps(timebase), cur_ps);
    chk(tx_valid, 1'b0);
    run("\164\144=?", 0, 0, 0, "TIME/DIV 100E+00 S\015\012");
    esc("\033[");
    run("\124\104,?", 0, 0, 0, "TIME/DIV 100E+00 S\015\012");
    run("\124\104 2MS", 0, 1, 0, "");
    esc("\033R");
    for (int k = 0; k < 6; k++) run(set_cmd[k], 1, 0, set_ps[k], "");
    repeat (3)
    begin
      n = $urandom_range(999, 1);
      run($sformatf("\164\144 %0dus", n), 1, 0, longint'(n) * 64'hF_4240, "");
      // the reply shows three digits and a negative exponent
      run("\164\144 ?", 0, 0, 0, $sformatf("TIME/DIV %0d%0d%0dE-06 S\015\012",
          n / 100, (n / 10) % 10, n % 10));
    end
    run("\164\144 12345678901234567890123456789012345", 0, 1, 0, "");
    run("XY ?", 0, 1, 0, "");
    esc("\033L");
    run("\124\104 1", 0, 1, 0, "");
    print_verdict();
  end
endmodule // test_srcp_parser
